// File: common/motion_regs_pkg.sv
// Purpose: Shared constants for the switch status and sequencer register bank
// Assumes: Word-wide register port driven by the serial front end, 7-bit addresses
// Notes:   Offsets are register indices as seen by the serial front end
package motion_regs_pkg;
    localparam logic [6:0]  OFS_SWITCH_REPORT   = 7'h41;
    localparam logic [6:0]  OFS_TABLE_CONTROL   = 7'h54;
    localparam logic [6:0]  OFS_CURRENT_SCALING = 7'h55;
    localparam logic [6:0]  OFS_STALL_MEASURE   = 7'h56;
    localparam logic [6:0]  OFS_POWER_STAGE     = 7'h57;
    localparam logic [6:0]  OFS_CHOPPER_DIVIDER = 7'h59;

    // Switch report bit positions
    localparam int SW_LIVE_LEFT    = 0;
    localparam int SW_LIVE_RIGHT   = 1;
    localparam int SW_LATCH_LEFT   = 2;
    localparam int SW_LATCH_RIGHT  = 3;
    localparam int SW_STOP_LEFT    = 4;
    localparam int SW_STOP_RIGHT   = 5;
    localparam int SW_STALL_HALT   = 6;

    // Table control fields
    localparam int TBL_LEN_LSB     = 0;
    localparam int TBL_LEN_MSB     = 3;
    localparam int TBL_STOP_BIT    = 8;
    localparam logic [3:0] TBL_LEN_MAX = 4'hB;
    localparam logic [8:0] TBL_CONTROL_RESET = 9'h000;

    // Current scaling fields
    localparam int CUR_RUN_LSB     = 0;
    localparam int CUR_RUN_MSB     = 4;
    localparam int CUR_RUN_MIX     = 7;
    localparam int CUR_IDLE_LSB    = 8;
    localparam int CUR_IDLE_MSB    = 12;
    localparam int CUR_IDLE_MIX    = 15;
    localparam int CUR_TRIP_LSB    = 16;
    localparam int CUR_TRIP_MSB    = 18;
    localparam logic [23:0] CUR_SCALING_RESET = 24'h000090;
    localparam logic [4:0]  AMP_FULL = 5'h10;

    // Driver status bit positions
    localparam int DRV_ERROR_BIT   = 0;
    localparam int DRV_OTPW_BIT    = 1;
    localparam int DRV_STALL_BIT   = 2;

    // Chopper divider limits
    localparam logic [11:0] CHOP_DIV_MIN   = 12'h060;
    localparam logic [11:0] CHOP_DIV_MAX   = 12'h332;
    localparam logic [11:0] CHOP_DIV_RESET = 12'h280;

    typedef enum logic [1:0] {
        AMP_RUN  = 2'b01,
        AMP_IDLE = 2'b10
    } amp_state_t;
endpackage

// File: design/coil_current_scaler.sv
// Purpose: Selects run or idle amplitude and scales two sine entries
// Assumes: Standstill is a level from the ramp logic; delay given in clock cycles
// Notes:   Amplitudes above sixteen are clamped to full scale
`timescale 1ns/10ps
module coil_current_scaler
    import motion_regs_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               resetn,
    input  wire logic [23:0]        scaling,
    input  wire logic               standstill,
    input  wire logic [23:0]        standby_delay,
    input  wire logic signed [11:0] entry_a,
    input  wire logic signed [11:0] entry_b,
    output logic signed [11:0]      coil_a,
    output logic signed [11:0]      coil_b,
    output logic                    driver_enable,
    output logic                    blend_decay_en,
    output logic                    idle_active
);
    amp_state_t  state_reg;
    logic [23:0] still_cnt_reg;
    logic [4:0]  amp_raw;
    logic [4:0]  amplitude;
    logic        mix_sel;

    // Standstill timer; any motion restarts it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            still_cnt_reg <= 24'h000000;
        end else if (!standstill) begin
            still_cnt_reg <= 24'h000000;
        end else if (still_cnt_reg != standby_delay) begin
            still_cnt_reg <= still_cnt_reg + 24'h000001;
        end
    end

    // Run or idle amplitude selection
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= AMP_RUN;
        end else begin
            case (state_reg)
                AMP_RUN: begin
                    if (standstill && still_cnt_reg == standby_delay) begin
                        state_reg <= AMP_IDLE;
                    end
                end
                AMP_IDLE: begin
                    if (!standstill) begin
                        state_reg <= AMP_RUN;
                    end
                end
                default: state_reg <= AMP_RUN;
            endcase
        end
    end

    // Field pick; clamp keeps the product inside twelve bits
    always_comb begin
        if (state_reg == AMP_IDLE) begin
            amp_raw = scaling[CUR_IDLE_MSB:CUR_IDLE_LSB];
            mix_sel = scaling[CUR_IDLE_MIX];
        end else begin
            amp_raw = scaling[CUR_RUN_MSB:CUR_RUN_LSB];
            mix_sel = scaling[CUR_RUN_MIX];
        end
        amplitude = (amp_raw > AMP_FULL) ? AMP_FULL : amp_raw;
    end

    // Registered scaled outputs
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            coil_a         <= 12'sh000;
            coil_b         <= 12'sh000;
            driver_enable  <= 1'b0;
            blend_decay_en <= 1'b0;
            idle_active    <= 1'b0;
        end else begin
            coil_a         <= 12'(18'(entry_a * $signed({1'b0, amplitude})) >>> 4);
            coil_b         <= 12'(18'(entry_b * $signed({1'b0, amplitude})) >>> 4);
            driver_enable  <= (amplitude != 5'h00); // Zero disables the driver
            blend_decay_en <= mix_sel;
            idle_active    <= (state_reg == AMP_IDLE);
        end
    end
endmodule

// File: design/switch_status_and_sequencer_config.sv
// Purpose: Switch status word and microstep sequencer configuration registers
// Assumes: Serial front end presents one-cycle read and write strobes per access
// Notes:   Read data is registered, valid the cycle after the read strobe
`timescale 1ns/10ps
module switch_status_and_sequencer_config
    import motion_regs_pkg::*;
(
    // Clock, reset and register port
    input  wire logic               clock,
    input  wire logic               resetn,
    input  wire logic [6:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_write,
    input  wire logic               reg_read,
    output logic [31:0]             reg_rdata,
    // Switch, latch and stop inputs
    input  wire logic               switch_left_active,
    input  wire logic               switch_right_active,
    input  wire logic               latch_left_captured,
    input  wire logic               latch_right_captured,
    input  wire logic               stop_left_active,
    input  wire logic               stop_right_active,
    input  wire logic               stall_stop_event,
    // Power stage sense inputs
    input  wire logic [2:0]         stall_value_in,
    input  wire logic               drv_error,
    input  wire logic               drv_otpw,
    input  wire logic               drv_stall,
    // Motion and sine table inputs
    input  wire logic               step_pulse,
    input  wire logic               step_dir,
    input  wire logic               standstill,
    input  wire logic [23:0]        standby_delay,
    input  wire logic signed [11:0] sine_a,
    input  wire logic signed [11:0] sine_b,
    // Sequencer and register outputs
    output logic [12:0]             table_index,
    output logic [11:0]             ustep_resolution,
    output logic [2:0]              stall_trip_level,
    output logic [11:0]             chopper_div,
    // Scaled coil outputs
    output logic signed [11:0]      coil_a,
    output logic signed [11:0]      coil_b,
    output logic                    driver_enable,
    output logic                    run_blend_decay_en,
    output logic                    idle_blend_decay_en,
    output logic                    blend_decay_en,
    output logic                    idle_active
);
    // Stored registers
    logic [8:0]  table_control_reg;
    logic [23:0] scaling_reg;
    logic [11:0] chopper_div_reg;
    logic [12:0] index_reg;

    // Status flags and decode
    logic        latch_left_reg;
    logic        latch_right_reg;
    logic        stall_halt_flag_reg;
    logic        status_read;
    logic [6:0]  switch_report;
    logic [3:0]  len_code;
    logic [12:0] step_amount;

    // Length code clamped so codes above full stepping act as full stepping
    function automatic logic [3:0] clamp_len(input logic [3:0] code);
        clamp_len = (code > TBL_LEN_MAX) ? TBL_LEN_MAX : code;
    endfunction

    // Index step per microstep input; stepping by 2^code keeps 8192 wrap
    function automatic logic [12:0] step_size(input logic [3:0] code);
        step_size = 13'h0001 << clamp_len(code);
    endfunction

    // Strobe qualified by one register offset
    function automatic logic hit(input logic strobe, input logic [6:0] addr,
                                 input logic [6:0] ofs);
        hit = strobe && (addr == ofs);
    endfunction

    // Status read strobe and the decoded length code
    assign status_read = hit(reg_read, reg_addr, OFS_SWITCH_REPORT);
    assign len_code    = table_control_reg[TBL_LEN_MSB:TBL_LEN_LSB];
    assign step_amount = step_size(len_code); // Codes past full stepping act as 11

    // Left latch ready; set beats clear, so an event during the read survives it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            latch_left_reg <= 1'b0;
        end else if (latch_left_captured) begin
            latch_left_reg <= 1'b1;
        end else if (status_read) begin
            latch_left_reg <= 1'b0;
        end
    end

    // Right latch ready, same priority as the left one
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            latch_right_reg <= 1'b0;
        end else if (latch_right_captured) begin
            latch_right_reg <= 1'b1;
        end else if (status_read) begin
            latch_right_reg <= 1'b0;
        end
    end

    // Stall stop flag; losing a stall to a racing clear would hide a fault
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stall_halt_flag_reg <= 1'b0;
        end else if (stall_stop_event) begin
            stall_halt_flag_reg <= 1'b1;
        end else if (status_read) begin
            stall_halt_flag_reg <= 1'b0;
        end
    end

    // Assembled status word; live bits are not stored
    always_comb begin
        switch_report                 = 7'h00;
        switch_report[SW_LIVE_LEFT]   = switch_left_active;
        switch_report[SW_LIVE_RIGHT]  = switch_right_active;
        switch_report[SW_LATCH_LEFT]  = latch_left_reg;
        switch_report[SW_LATCH_RIGHT] = latch_right_reg;
        switch_report[SW_STOP_LEFT]   = stop_left_active;
        switch_report[SW_STOP_RIGHT]  = stop_right_active;
        switch_report[SW_STALL_HALT]  = stall_halt_flag_reg;
    end

    // Sequencer mode register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            table_control_reg <= TBL_CONTROL_RESET;
        end else if (hit(reg_write, reg_addr, OFS_TABLE_CONTROL)) begin
            table_control_reg <= reg_wdata[8:0];
        end
    end

    // Current scaling register; also carries the stall trip level
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scaling_reg <= CUR_SCALING_RESET;
        end else if (hit(reg_write, reg_addr, OFS_CURRENT_SCALING)) begin
            scaling_reg <= reg_wdata[23:0];
        end
    end

    // Chopper divider; too small a divider is unsafe for the power stage
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            chopper_div_reg <= CHOP_DIV_RESET;
        end else if (hit(reg_write, reg_addr, OFS_CHOPPER_DIVIDER)) begin
            if (reg_wdata[11:0] < CHOP_DIV_MIN) begin
                chopper_div_reg <= CHOP_DIV_MIN;
            end else begin
                chopper_div_reg <= reg_wdata[11:0];
            end
        end
    end

    // Read mux, pre-clear values captured with the strobe
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_read) begin
            case (reg_addr)
                OFS_SWITCH_REPORT: reg_rdata <= {25'h0000000, switch_report};
                OFS_TABLE_CONTROL: reg_rdata <= {23'h000000, table_control_reg};
                OFS_STALL_MEASURE: reg_rdata <= {29'h00000000, stall_value_in};
                OFS_POWER_STAGE:   reg_rdata <= {29'h00000000, drv_stall,
                                                 drv_otpw, drv_error};
                default:           reg_rdata <= 32'h00000000; // Write-only and unmapped
            endcase
        end
    end

    // Table index advance, frozen while the stop bit is set
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            index_reg <= 13'h0000;
        end else if (step_pulse && !table_control_reg[TBL_STOP_BIT]) begin
            if (step_dir) begin
                index_reg <= index_reg + step_amount;
            end else begin
                index_reg <= index_reg - step_amount;
            end
        end
    end

    // Microsteps per full step: 8192 >> code, then a quarter of that
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ustep_resolution <= 12'h000;
        end else begin
            ustep_resolution <= 12'(14'h0800 >> clamp_len(len_code));
        end
    end

    // Register views on the ports
    assign table_index         = index_reg;
    assign chopper_div         = chopper_div_reg;

    // Trip level shares the current scaling register
    assign stall_trip_level    = scaling_reg[CUR_TRIP_MSB:CUR_TRIP_LSB];

    // Blend decay enables as stored
    assign run_blend_decay_en  = scaling_reg[CUR_RUN_MIX];
    assign idle_blend_decay_en = scaling_reg[CUR_IDLE_MIX];

    // Amplitude scaling and standby switch-over
    coil_current_scaler scaler (
        .clock          (clock),
        .resetn         (resetn),
        .scaling        (scaling_reg),
        .standstill     (standstill),
        .standby_delay  (standby_delay),
        .entry_a        (sine_a),
        .entry_b        (sine_b),
        .coil_a         (coil_a),
        .coil_b         (coil_b),
        .driver_enable  (driver_enable),
        .blend_decay_en (blend_decay_en),
        .idle_active    (idle_active)
    );
endmodule

// File: test/switch_status_assertions.sv
// Purpose: Port checks of the switch status and sequencer register bank
// Assumes: One clock, one-cycle strobes, read data valid the cycle after
// Notes:   Table control mirrored from host writes, the register is internal
`timescale 1ns/10ps
module switch_status_assertions
    import motion_regs_pkg::*;
(
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic [6:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        switch_left_active,
    input wire logic        switch_right_active,
    input wire logic        latch_left_captured,
    input wire logic        latch_right_captured,
    input wire logic        stall_stop_event,
    input wire logic [12:0] table_index,
    input wire logic [11:0] ustep_resolution,
    input wire logic [11:0] chopper_div
);
    logic        rd41, w54, w59, quiet;
    logic [8:0]  ctrl_q;
    logic [11:0] wlow;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Decoded strobes; quiet means no flag event in that cycle
    assign rd41  = reg_read && reg_addr == OFS_SWITCH_REPORT;
    assign w54   = reg_write && reg_addr == OFS_TABLE_CONTROL;
    assign w59   = reg_write && reg_addr == OFS_CHOPPER_DIVIDER;
    assign quiet = !(latch_left_captured || latch_right_captured || stall_stop_event);
    assign wlow  = reg_wdata[11:0];
    // Mirror of table control, updated on the same edge as the design's
    always_ff @(posedge clock or negedge resetn)
        if (!resetn) ctrl_q <= 9'h000;
        else if (w54) ctrl_q <= reg_wdata[8:0];
    sequence s_quiet_read;
        rd41 && quiet;
    endsequence
    a_live_switches: assert property (rd41 |=>
        reg_rdata[0] == $past(switch_left_active) && reg_rdata[1] == $past(switch_right_active))
        else $error("live switch bits");
    a_flags_cleared: assert property (s_quiet_read ##1 s_quiet_read |=>
        reg_rdata[6] == 1'b0 && reg_rdata[3:2] == 2'b00) else $error("flags not cleared");
    a_stall_set_wins: assert property (stall_stop_event && rd41 ##1 rd41 |=>
        reg_rdata[6]) else $error("stall flag lost during read");
    a_latch_set_wins: assert property (latch_right_captured && rd41 ##1 rd41 |=>
        reg_rdata[3]) else $error("latch flag lost during read");
    a_div_floor: assert property (w59 && wlow < CHOP_DIV_MIN |=>
        chopper_div == CHOP_DIV_MIN) else $error("divider below floor");
    a_div_keep: assert property (w59 && wlow >= CHOP_DIV_MIN |=>
        chopper_div == $past(wlow)) else $error("divider not stored");
    a_table_resolution: assert property (w54 &&
        reg_wdata[3:0] <= TBL_LEN_MAX ##1 !w54 |=>
        ustep_resolution == 12'(12'h800 >> ctrl_q[3:0]))
        else $error("resolution wrong");
    a_stop_holds: assert property (ctrl_q[TBL_STOP_BIT] |=> $stable(table_index))
        else $error("index moved while stopped");
endmodule
bind switch_status_and_sequencer_config switch_status_assertions u_checker (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .switch_left_active(switch_left_active), .switch_right_active(switch_right_active),
    .latch_left_captured(latch_left_captured), .latch_right_captured(latch_right_captured),
    .stall_stop_event(stall_stop_event), .table_index(table_index),
    .ustep_resolution(ustep_resolution), .chopper_div(chopper_div));

// File: test/host_model.sv
// Purpose: Host side of the register port, one access at a time
// Assumes: Strobes one cycle wide, read data settled after the taking edge
// Notes:   Released write data is inverted so a stale word cannot match
`timescale 1ns/10ps
module host_model (
    input  wire logic        clock,
    output logic [6:0]       reg_addr,
    output logic [31:0]      reg_wdata,
    output logic             reg_write,
    output logic             reg_read,
    input  wire logic [31:0] reg_rdata
);
    // Quiet port at time zero
    initial {reg_addr, reg_wdata, reg_write, reg_read} = '0;
    // Single write strobe
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(posedge clock);
        {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
        @(posedge clock);
        {reg_wdata, reg_write} <= {~d, 1'b0};
        #1;
    endtask
    // n reads back to back; d1 gets the last word, d0 the one before
    task automatic rd(input logic [6:0] a, input int n, output logic [31:0] d0, d1);
        @(posedge clock);
        {reg_addr, reg_read} <= {a, 1'b1};
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            if (i == n - 1) reg_read <= 1'b0;
            #1;
            d0 = d1;
            d1 = reg_rdata;
        end
    endtask
endmodule

// File: test/switch_status_and_sequencer_config_tb.sv
// Purpose: Self-checking bench for the switch status and sequencer register bank
// Assumes: Host model gives one-cycle strobes; standby delay of four cycles
// Notes:   Short fixed waits follow the one-cycle register latencies
`timescale 1ns/10ps
module switch_status_and_sequencer_config_tb
    import motion_regs_pkg::*;
;
    logic clock, resetn, reg_write, reg_read, step_pulse, step_dir, standstill, driver_enable;
    logic switch_left_active, switch_right_active, stop_left_active, stop_right_active;
    logic latch_left_captured, latch_right_captured, stall_stop_event, drv_error, drv_otpw;
    logic drv_stall, run_blend_decay_en, idle_blend_decay_en, blend_decay_en, idle_active;
    logic        [2:0]  stall_value_in, stall_trip_level;
    logic        [6:0]  reg_addr;
    logic        [11:0] ustep_resolution;
    logic        [11:0] chopper_div;
    logic        [12:0] table_index, idx;
    logic        [23:0] standby_delay;
    logic        [31:0] reg_wdata, reg_rdata, d0, d1;
    logic signed [11:0] sine_a, sine_b, coil_a, coil_b;
    int                 err_count = 0;
    int                 n_checks = 0;
    switch_status_and_sequencer_config uut (.clock(clock), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .switch_left_active(switch_left_active),
        .switch_right_active(switch_right_active), .latch_left_captured(latch_left_captured),
        .latch_right_captured(latch_right_captured), .stop_left_active(stop_left_active),
        .stop_right_active(stop_right_active), .stall_stop_event(stall_stop_event),
        .stall_value_in(stall_value_in), .drv_error(drv_error), .drv_otpw(drv_otpw),
        .drv_stall(drv_stall), .step_pulse(step_pulse), .step_dir(step_dir),
        .standstill(standstill), .standby_delay(standby_delay), .sine_a(sine_a),
        .sine_b(sine_b), .table_index(table_index), .ustep_resolution(ustep_resolution),
        .stall_trip_level(stall_trip_level), .chopper_div(chopper_div), .coil_a(coil_a),
        .coil_b(coil_b), .driver_enable(driver_enable), .run_blend_decay_en(run_blend_decay_en),
        .idle_blend_decay_en(idle_blend_decay_en), .blend_decay_en(blend_decay_en),
        .idle_active(idle_active));
    host_model hm (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
    always #5 clock = ~clock;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic pulse_step(input logic dir);
        @(posedge clock);
        {step_dir, step_pulse} <= {dir, 1'b1};
        @(posedge clock);
        step_pulse <= 1'b0;
        #1;
    endtask
    // Reset values, refused places, divider floor, table length, stop bit
    task automatic t_regs();
        logic [23:0] cv [4] = '{24'h032060, 24'h05F060, 24'h332332, 24'h280280};
        int s;
        check(chopper_div, CHOP_DIV_RESET);
        check({run_blend_decay_en, idle_blend_decay_en}, 2'b10);
        hm.wr(OFS_POWER_STAGE, 32'h7);
        hm.rd(OFS_POWER_STAGE, 1, d0, d1);
        check(d1, 32'h0);
        hm.rd(OFS_CURRENT_SCALING, 1, d0, d1);
        check(d1, 32'h0);
        check(ustep_resolution, 32'h800);
        foreach (cv[i]) begin
            hm.wr(OFS_CHOPPER_DIVIDER, {20'h0, cv[i][23:12]});
            check(chopper_div, cv[i][11:0]);
        end
        for (int c = 1; c < 16; c++) begin
            s = (c > 11) ? 11 : c;
            hm.wr(OFS_TABLE_CONTROL, 32'(c));
            hm.rd(OFS_TABLE_CONTROL, 1, d0, d1);
            check(d1, 32'(c));
            check(ustep_resolution, 12'(12'h800 >> s));
            idx = table_index;
            pulse_step(c[0]);
            check(table_index, 13'(c[0] ? idx + (13'h1 << s) : idx - (13'h1 << s)));
        end
        hm.wr(OFS_TABLE_CONTROL, 32'h10B);
        idx = table_index;
        pulse_step(1'b1);
        check(table_index, idx);
        $display("t_regs done");
    endtask
    // Live levels, read-clear flags, events arriving during a read
    task automatic t_status();
        @(posedge clock);
        {switch_left_active, stop_right_active, latch_left_captured, latch_right_captured,
         stall_stop_event} <= 5'h1F;
        @(posedge clock);
        {latch_left_captured, latch_right_captured, stall_stop_event} <= 3'h0;
        hm.rd(OFS_SWITCH_REPORT, 1, d0, d1);
        check(d1, 32'h6D);
        fork
            hm.rd(OFS_SWITCH_REPORT, 2, d0, d1);
            begin
                @(posedge clock);
                {latch_left_captured, latch_right_captured, stall_stop_event} <= 3'h7;
                @(posedge clock);
                {latch_left_captured, latch_right_captured, stall_stop_event} <= 3'h0;
            end
        join
        check(d0, 32'h21);
        check(d1, 32'h6D);
        @(posedge clock);
        {switch_left_active, switch_right_active, stop_left_active, stop_right_active} <= 4'h6;
        hm.rd(OFS_SWITCH_REPORT, 2, d0, d1);
        check(d0, 32'h12);
        check(d1, 32'h12);
        $display("t_status done");
    endtask
    // Driver readback and stall measurement levels, trip level field
    task automatic t_sense();
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            {drv_stall, drv_otpw, drv_error, stall_value_in} <= {3'(i), 3'(7 - i)};
            hm.rd(OFS_POWER_STAGE, 1, d0, d1);
            check(d1, 32'(i));
            hm.rd(OFS_STALL_MEASURE, 1, d0, d1);
            check(d1, 32'(7 - i));
        end
        hm.wr(OFS_CURRENT_SCALING, 32'h0005_0090);
        check(stall_trip_level, 3'h5);
        $display("t_sense done");
    endtask
    // Run amplitude 8, idle amplitude 4 with blend; zero amplitude disables
    task automatic t_coil();
        @(posedge clock);
        {sine_a, sine_b} <= {12'sd400, -12'sd160};
        hm.wr(OFS_CURRENT_SCALING, 32'h0000_8408);
        repeat (2) @(posedge clock);
        #1;
        check(coil_a, 12'sd200);
        check(coil_b, -12'sd80);
        check({blend_decay_en, idle_active, driver_enable}, 3'b001);
        @(posedge clock);
        standstill <= 1'b1;
        repeat (10) @(posedge clock);
        #1;
        check(coil_a, 12'sd100);
        check({blend_decay_en, idle_active}, 2'b11);
        hm.wr(OFS_CURRENT_SCALING, 32'h0000_0008);
        repeat (2) @(posedge clock);
        #1;
        check(driver_enable, 1'b0);
        $display("t_coil done");
    endtask
    // Inputs quiet at time zero, reset held five cycles
    initial begin
        {clock, resetn, switch_left_active, switch_right_active, stop_left_active,
         stop_right_active, latch_left_captured, latch_right_captured, stall_stop_event,
         drv_error, drv_otpw, drv_stall, step_pulse, step_dir, standstill} = '0;
        {stall_value_in, sine_a, sine_b, standby_delay} = {27'h0, 24'h000004};
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        t_regs();
        t_status();
        t_sense();
        t_coil();
        final_report();
    end
    // Tests need well under a thousand cycles; far longer means a hang
    initial begin
        #50000;
        err_count++;
        final_report();
    end
endmodule
